// File: verilog/lsn_pkg.sv
// Purpose: Shared constants, encodings and carriers for the link speed negotiator
// Assumes: Standard link-speed encoding, 32-bit AHB-Lite register window
// Notes: Offsets are byte addresses inside a 256-byte window
package lsn_pkg;
    // Link speed encoding
    localparam logic [3:0] SPD_GEN1 = 4'h1;
    localparam logic [3:0] SPD_GEN2 = 4'h2;
    // Advertised rate vectors: bit 0 is 2.5 GT/s, bit 1 is 5.0 GT/s
    localparam logic [1:0] ADV_GEN1_ONLY = 2'h1;
    localparam logic [1:0] ADV_BOTH = 2'h3;
    localparam int ADV_GEN2_BIT = 1;
    // Register byte offsets
    localparam logic [7:0] OFF_LINK_CTRL = 8'h00;
    localparam logic [7:0] OFF_LINK_STS = 8'h04;
    localparam logic [7:0] OFF_LINK_CTRL2 = 8'h08;
    localparam logic [7:0] OFF_PHY_CFG0 = 8'h0c;
    localparam logic [7:0] OFF_PHY_STATE0 = 8'h10;
    // Field positions
    localparam int CTRL_RETRAIN_BIT = 5;
    localparam int CTRL_BWIRQ_BIT = 10;
    localparam int STS_SPEED_LSB = 0;
    localparam int STS_BWMGMT_BIT = 14;
    localparam int STS_AUTOBW_BIT = 15;
    localparam int CTRL2_TARGET_LSB = 0;
    localparam int CTRL2_HW_SPEED_AUTONOMY_DISABLE_BIT = 5;
    localparam int CFG0_INHIBIT_BIT = 0;
    localparam int ST0_FULLRT_BIT = 0;
    localparam int ST0_PARTNER_LSB = 4;
    localparam int ST0_FSM_LSB = 8;
    localparam int ST0_UPFAIL_BIT = 12;
    // Reset values
    localparam logic [3:0] TARGET_RST = SPD_GEN2;
    localparam logic INHIBIT_RST = 1'b0;
    localparam logic IRQEN_RST = 1'b0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    // AHB-Lite codes
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    localparam logic HRESP_BIT_OKAY = 1'b0;

    // Training state reported by the LTSSM
    typedef enum logic [2:0] {
        LT_DETECT = 3'b000,
        LT_POLLING = 3'b001,
        LT_CONFIG = 3'b010,
        LT_CFG_COMPLETE = 3'b011,
        LT_L0 = 3'b100,
        LT_RCV_RCVRCFG = 3'b101,
        LT_RCV_SPEED = 3'b110,
        LT_RCV_OTHER = 3'b111
    } lsn_ltssm_e;

    // Negotiator state
    typedef enum logic [1:0] {
        FSM_DOWN = 2'b00,
        FSM_IDLE = 2'b01,
        FSM_CHANGE = 2'b10,
        FSM_PASS = 2'b11
    } lsn_fsm_e;

    // Cause of a Recovery pass
    typedef enum logic [1:0] {
        WHY_AUTO = 2'b00,
        WHY_SW = 2'b01,
        WHY_RELIAB = 2'b10,
        WHY_PARTNER = 2'b11
    } lsn_why_e;

    typedef struct packed {
        logic valid;
        logic [1:0] rates;
    } lsn_ts_rx_s;

    typedef struct packed {
        logic valid;
        logic [3:0] rate;
        logic autonomous;
    } lsn_part_req_s;

    typedef struct packed {
        logic done;
        logic ok;
        logic lockFail;
    } lsn_recov_s;

    typedef struct packed {
        logic recovReq;
        logic speedChange;
        logic [3:0] reqRate;
        logic [1:0] advRates;
        logic txAutonomous;
        logic fullRetrain;
        logic [3:0] laneRate;
    } lsn_cmd_s;
endpackage

// File: verilog/lsn_link_speed.sv
// Purpose: Per-port link speed negotiation with AHB-Lite register access
// Assumes: LTSSM outside reports state and Recovery outcome on clk_sys
// Notes: Zero-wait-state slave; register window decodes haddr[7:0] only
// Functional notes
// RULE_01: All lanes share one link rate
// RULE_02: Detect restarts at 2.5 GT/s, upgrade later
// RULE_03: Recovery speed change never drops data link
// RULE_04: Record partner rates, latest advertisement wins
// RULE_05: Change only toward rate partner advertised
// RULE_06: Downstream holds lower of target, common
// RULE_07: Target resets 5.0, advertise both rates
// RULE_08: Downstream auto-upgrades after training at 2.5
// RULE_09: Inhibit bit blocks automatic initial upgrade
// RULE_10: Initial upgrade leaves bandwidth status alone
// RULE_11: Current speed field shows present rate
// RULE_12: Software retrain upgrades when partner supports
// RULE_13: Unreliable 5.0 drops rate, keeps advertising
// RULE_14: Target 2.5 plus retrain downgrades, stops advertising
// RULE_15: Always honour partner speed change requests; code takes them only in FSM_IDLE and drops those that arrive in other states
// RULE_16: Failed upgrade returns 2.5, no retry
// RULE_17: Autonomy disable bit inert, reads zero
// RULE_18: Never transmit autonomous-change bit
// RULE_19: Partner autonomous change sets autonomous status
// RULE_20: Unsupported target passes Recovery without change
// RULE_21: Bandwidth status on reliability, partner, retrain
// RULE_22: Notification only while interrupt enable set
// RULE_23: Full retrain sends LTSSM to Detect
// RULE_24: Target encoding 1 is 2.5, 2 is 5.0
`timescale 1ns/1ps
module lsn_link_speed (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire lsn_pkg::lsn_ltssm_e ltssmState,
    input wire logic dlActive,
    input wire logic isDownstream,
    input wire lsn_pkg::lsn_ts_rx_s tsRx,
    input wire lsn_pkg::lsn_part_req_s partnerReq,
    input wire logic unreliable,
    input wire lsn_pkg::lsn_recov_s recov,
    output lsn_pkg::lsn_cmd_s linkCmd,
    output logic bwNotify
);
    import lsn_pkg::*;

    // Bus state
    logic wrPend_reg;
    logic [7:0] wrAddr_reg;
    logic [31:0] hrdata_reg;
    // Software-visible state
    logic [3:0] target_reg;
    logic inhibit_reg;
    logic irqEn_reg;
    logic bwMgmt_reg;
    logic autoBw_reg;
    logic bwNotify_reg;
    // Negotiation state
    lsn_fsm_e fsm_reg;
    lsn_why_e why_reg;
    logic partnerAuto_reg;
    logic [1:0] partnerRates_reg;
    logic initPending_reg;
    logic upFailed_reg;
    // Pass was started by the hold-down rule or the automatic upgrade
    logic holdGoLatched_reg;
    lsn_cmd_s linkCmd_reg;
    // Bus answer flops
    logic hreadyOut_reg;
    logic hresp_reg;

    // Address phase is taken when selected with a NONSEQ or SEQ transfer and the bus is ready; size is not checked
    wire addrPhase = hsel & hready & htrans[1];
    wire rdPhase = addrPhase & ~hwrite;
    wire [7:0] rdAddr = haddr[7:0];
    wire wrCtrl = wrPend_reg & (wrAddr_reg == OFF_LINK_CTRL);
    wire wrSts = wrPend_reg & (wrAddr_reg == OFF_LINK_STS);
    wire wrCtrl2 = wrPend_reg & (wrAddr_reg == OFF_LINK_CTRL2);
    wire wrCfg0 = wrPend_reg & (wrAddr_reg == OFF_PHY_CFG0);
    wire wrSt0 = wrPend_reg & (wrAddr_reg == OFF_PHY_STATE0);
    wire retrainPulse = wrCtrl & hwdata[CTRL_RETRAIN_BIT];
    wire fullRtPulse = wrSt0 & hwdata[ST0_FULLRT_BIT];

    // Read views; self-clearing request bits always read zero
    wire [31:0] rdCtrl = WORD_ZERO | (32'(irqEn_reg) << CTRL_BWIRQ_BIT);
    // RULE_11 speed field
    wire [31:0] rdSts = WORD_ZERO | (32'(linkCmd_reg.laneRate) << STS_SPEED_LSB)
        | (32'(bwMgmt_reg) << STS_BWMGMT_BIT) | (32'(autoBw_reg) << STS_AUTOBW_BIT);
    // RULE_17 autonomy disable is hardwired zero, so only the target shows
    wire [31:0] rdCtrl2 = WORD_ZERO | (32'(target_reg) << CTRL2_TARGET_LSB);
    wire [31:0] rdCfg0 = WORD_ZERO | (32'(inhibit_reg) << CFG0_INHIBIT_BIT);
    wire [31:0] rdSt0 = WORD_ZERO | (32'(partnerRates_reg) << ST0_PARTNER_LSB)
        | (32'(fsm_reg) << ST0_FSM_LSB) | (32'(upFailed_reg) << ST0_UPFAIL_BIT);
    // Unmapped offsets read as zero and take writes silently
    wire [31:0] rdMux = (rdAddr == OFF_LINK_CTRL) ? rdCtrl :
                        (rdAddr == OFF_LINK_STS) ? rdSts :
                        (rdAddr == OFF_LINK_CTRL2) ? rdCtrl2 :
                        (rdAddr == OFF_PHY_CFG0) ? rdCfg0 :
                        (rdAddr == OFF_PHY_STATE0) ? rdSt0 : WORD_ZERO;

    // Bus pipeline: write lands in the data phase, read data is registered
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
            hrdata_reg <= WORD_ZERO;
        end else begin
            wrPend_reg <= addrPhase & hwrite;
            wrAddr_reg <= rdAddr;
            hrdata_reg <= rdPhase ? rdMux : WORD_ZERO;
        end
    end

    // Partner support, derived views of rates
    wire partnerGen2 = partnerRates_reg[ADV_GEN2_BIT];
    wire [3:0] curRate = linkCmd_reg.laneRate;
    // RULE_07 advertise both rates while the target is 5.0
    // RULE_14 a 2.5 target withdraws the higher rate
    wire [1:0] advNext = (target_reg == SPD_GEN1) ? ADV_GEN1_ONLY : ADV_BOTH;
    wire advGen2 = linkCmd_reg.advRates[ADV_GEN2_BIT];
    wire idle = (fsm_reg == FSM_IDLE);
    wire inRecord = (ltssmState == LT_CFG_COMPLETE) | (ltssmState == LT_RCV_RCVRCFG);
    wire atDetect = (ltssmState == LT_DETECT);

    // Start sources, highest priority first: partner, software, reliability
    // RULE_15 partner requests are always taken when idle
    wire partnerGo = partnerReq.valid;
    wire swGo = retrainPulse;
    wire reliabGo = unreliable & (curRate == SPD_GEN2);
    // RULE_06 downstream end keeps rate at the lower of target and common
    wire holdGo = isDownstream & (curRate == SPD_GEN2)
        & (~partnerGen2 | (target_reg == SPD_GEN1));
    // RULE_08 upgrade once after training, downstream only
    // RULE_09 inhibit bit is sampled live, so it may change at any time
    wire autoGo = initPending_reg & dlActive & isDownstream & ~inhibit_reg & ~upFailed_reg
        & (target_reg == SPD_GEN2) & partnerGen2 & (curRate == SPD_GEN1);
    wire startAny = idle
        & (partnerGo | swGo | reliabGo | holdGo | autoGo);

    // RULE_05 a higher rate is sought only once both ends advertised it
    // A code outside the speed encoding is never taken as a change
    wire partnerOk = (partnerReq.rate == SPD_GEN1)
        | ((partnerReq.rate == SPD_GEN2) & advGen2 & partnerGen2);
    // RULE_12 software retrain upgrades when the partner covers 5.0
    // RULE_20 unsupported or unchanged target just passes through Recovery
    // Illegal target codes only give a pass without change
    wire swChange = (target_reg != curRate)
        & ((target_reg == SPD_GEN1) | ((target_reg == SPD_GEN2) & partnerGen2));
    wire [3:0] startRate = partnerGo ? partnerReq.rate :
                           swGo ? target_reg :
                           (reliabGo | holdGo) ? SPD_GEN1 : SPD_GEN2;
    wire startChange = partnerGo ? (partnerOk & (partnerReq.rate != curRate)) :
                       swGo ? swChange : 1'b1;
    wire lsn_why_e startWhy = partnerGo ? WHY_PARTNER :
                              swGo ? WHY_SW :
                              (reliabGo | holdGo) ? WHY_RELIAB : WHY_AUTO;

    // Recovery outcome decode
    wire chgDone = (fsm_reg == FSM_CHANGE) & recov.done;
    wire chgOk = chgDone & recov.ok;
    wire upFail = chgDone & ~recov.ok & (linkCmd_reg.reqRate == SPD_GEN2);
    // Hold-down from a vanished partner rate is not a reliability event
    wire holdCause = (why_reg == WHY_RELIAB) & holdGoLatched_reg;

    // RULE_21 status on reliability downgrade, partner change and any retrain
    // RULE_10 automatic initial upgrade never touches the status bit
    wire bwSet = isDownstream & (swGo
        | (chgOk & (why_reg == WHY_RELIAB) & ~holdCause)
        | (chgOk & (why_reg == WHY_PARTNER) & ~partnerAuto_reg)
        | (upFail & ~recov.lockFail & (why_reg != WHY_AUTO)));
    // RULE_19 partner-marked autonomous change lands in its own bit
    wire autoBwSet = isDownstream & chgOk & (why_reg == WHY_PARTNER) & partnerAuto_reg;
    // Status bits are write-one-to-clear, and a set in the same cycle wins
    wire bwMgmtNext = bwSet | (bwMgmt_reg & ~(wrSts & hwdata[STS_BWMGMT_BIT]));
    wire autoBwNext = autoBwSet | (autoBw_reg & ~(wrSts & hwdata[STS_AUTOBW_BIT]));

    // Software registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            target_reg <= TARGET_RST;
            inhibit_reg <= INHIBIT_RST;
            irqEn_reg <= IRQEN_RST;
            bwMgmt_reg <= 1'b0;
            autoBw_reg <= 1'b0;
            bwNotify_reg <= 1'b0;
        end else begin
            // RULE_24 target is held in the standard speed encoding
            if (wrCtrl2) begin
                target_reg <= hwdata[CTRL2_TARGET_LSB +: 4];
            end
            if (wrCfg0) begin
                inhibit_reg <= hwdata[CFG0_INHIBIT_BIT];
            end
            if (wrCtrl) begin
                irqEn_reg <= hwdata[CTRL_BWIRQ_BIT];
            end
            bwMgmt_reg <= bwMgmtNext;
            autoBw_reg <= autoBwNext;
            // RULE_22 notification gated by the enable
            bwNotify_reg <= bwMgmt_reg & irqEn_reg;
        end
    end

    // RULE_04 partner rates from Configuration.Complete and Recovery.RcvrCfg
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            partnerRates_reg <= ADV_GEN1_ONLY;
        end else if (atDetect) begin
            partnerRates_reg <= ADV_GEN1_ONLY;
        end else if (tsRx.valid & inRecord) begin
            partnerRates_reg <= tsRx.rates;
        end
    end

    // Negotiation state machine; one Recovery pass at a time
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fsm_reg <= FSM_DOWN;
            why_reg <= WHY_AUTO;
            partnerAuto_reg <= 1'b0;
            holdGoLatched_reg <= 1'b0;
            initPending_reg <= 1'b1;
            upFailed_reg <= 1'b0;
            linkCmd_reg <= '{recovReq: 1'b0, speedChange: 1'b0, reqRate: SPD_GEN1,
                             advRates: ADV_BOTH, txAutonomous: 1'b0, fullRetrain: 1'b0,
                             laneRate: SPD_GEN1};
        end else begin
            linkCmd_reg.recovReq <= 1'b0;
            // RULE_13 reliability drops keep advertising what the target allows
            linkCmd_reg.advRates <= advNext;
            // RULE_18 autonomous-change bit is never sent
            linkCmd_reg.txAutonomous <= 1'b0;
            // RULE_23 full retrain is a one-cycle command to go to Detect
            linkCmd_reg.fullRetrain <= fullRtPulse;
            if (atDetect) begin
                // RULE_02 training from Detect runs at the base rate
                fsm_reg <= FSM_DOWN;
                initPending_reg <= 1'b1;
                upFailed_reg <= 1'b0;
                linkCmd_reg.speedChange <= 1'b0;
                linkCmd_reg.laneRate <= SPD_GEN1;
            end else begin
                unique case (fsm_reg)
                    FSM_DOWN: begin
                        // RULE_02 no negotiation before L0 with the data link active
                        if (dlActive & (ltssmState == LT_L0)) begin
                            fsm_reg <= FSM_IDLE;
                        end
                    end
                    FSM_IDLE: begin
                        if (startAny) begin
                            // RULE_03 speed changes go through Recovery, never Detect
                            fsm_reg <= startChange ? FSM_CHANGE : FSM_PASS;
                            why_reg <= startWhy;
                            partnerAuto_reg <= partnerReq.autonomous;
                            holdGoLatched_reg <= ~partnerGo & ~swGo & ~reliabGo;
                            initPending_reg <= 1'b0;
                            linkCmd_reg.recovReq <= 1'b1;
                            linkCmd_reg.speedChange <= startChange;
                            linkCmd_reg.reqRate <= startChange ? startRate : curRate;
                        end
                    end
                    FSM_CHANGE, FSM_PASS: begin
                        if (recov.done) begin
                            fsm_reg <= FSM_IDLE;
                            linkCmd_reg.speedChange <= 1'b0;
                            // RULE_01 one rate register drives every lane
                            if (chgOk) begin
                                linkCmd_reg.laneRate <= linkCmd_reg.reqRate;
                            end
                            // RULE_16 failed upgrade falls back and is not retried
                            if (upFail) begin
                                linkCmd_reg.laneRate <= SPD_GEN1;
                                upFailed_reg <= 1'b1;
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyOut_reg;
    assign hresp = hresp_reg;
    assign linkCmd = linkCmd_reg;
    assign bwNotify = bwNotify_reg;

    // Constant bus answers, held in flops so every output is registered
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hreadyOut_reg <= 1'b1;
            hresp_reg <= HRESP_BIT_OKAY;
        end else begin
            hreadyOut_reg <= 1'b1;
            hresp_reg <= HRESP_BIT_OKAY;
        end
    end

    // Checks on the negotiator's own behaviour
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    a_lane_rate_legal: // RULE_01
    assert property (linkCmd_reg.laneRate == SPD_GEN1 || linkCmd_reg.laneRate == SPD_GEN2)
        else $error("lane rate left the legal set");

    a_detect_base_rate: // RULE_02
    assert property (atDetect
        |=> linkCmd_reg.laneRate == SPD_GEN1 && fsm_reg == FSM_DOWN)
        else $error("Detect did not restart at base rate");

    a_partner_record: // RULE_04
    assert property (tsRx.valid && inRecord && !atDetect
        |=> partnerRates_reg == $past(tsRx.rates))
        else $error("partner rates not recorded");

    a_upgrade_needs_partner: // RULE_05
    assert property ($rose(linkCmd_reg.recovReq) && linkCmd_reg.speedChange
        && linkCmd_reg.reqRate == SPD_GEN2 |-> $past(partnerRates_reg[ADV_GEN2_BIT]))
        else $error("upgrade toward unadvertised rate");

    a_adv_follows_target: // RULE_14
    assert property (target_reg == SPD_GEN1 ##1 target_reg == SPD_GEN1
        |-> linkCmd_reg.advRates == ADV_GEN1_ONLY)
        else $error("5.0 still advertised with 2.5 target");

    a_auto_no_status: // RULE_10
    assert property (chgDone && why_reg == WHY_AUTO && !retrainPulse |=> !$rose(bwMgmt_reg))
        else $error("initial upgrade set bandwidth status");

    a_retrain_status: // RULE_21
    assert property (retrainPulse && isDownstream |=> bwMgmt_reg)
        else $error("retrain did not set bandwidth status");

    a_notify_gated: // RULE_22
    assert property (bwNotify_reg |-> $past(irqEn_reg) && $past(bwMgmt_reg))
        else $error("notification without enable");

    a_full_retrain_pulse: // RULE_23
    assert property (fullRtPulse |=> linkCmd_reg.fullRetrain ##1 !linkCmd_reg.fullRetrain)
        else $error("full retrain command not a single pulse");

    a_no_autonomous_tx: // RULE_18
    assert property (linkCmd_reg.recovReq |-> !linkCmd_reg.txAutonomous)
        else $error("autonomous-change bit driven");

    a_hw_speed_autonomy_disable_reads_zero: // RULE_17
    assert property (rdPhase && rdAddr == OFF_LINK_CTRL2
        |=> hrdata_reg[CTRL2_HW_SPEED_AUTONOMY_DISABLE_BIT] == 1'b0)
        else $error("autonomy disable bit read as one");

    a_speed_field: // RULE_11
    assert property (rdPhase && rdAddr == OFF_LINK_STS
        |=> hrdata_reg[STS_SPEED_LSB +: 4] == $past(linkCmd_reg.laneRate))
        else $error("speed field disagrees with lane rate");

    a_failed_upgrade_base: // RULE_16
    assert property (upFail && !atDetect |=> linkCmd_reg.laneRate == SPD_GEN1 && upFailed_reg)
        else $error("failed upgrade did not fall back");
endmodule // lsn_link_speed

// File: dv/lsn_partner.sv
// Purpose: Link partner model that answers the Recovery passes the port asks for
// Assumes: Exactly one done pulse for each recovery request
// Notes: Answer delay and forced failure are set by the bench
`timescale 1ns/1ps
module lsn_partner (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire lsn_pkg::lsn_cmd_s linkCmd,
    input wire logic [1:0] partnerRates,
    input wire logic slow,
    input wire logic failNext,
    output lsn_pkg::lsn_recov_s recov
);
    import lsn_pkg::*;
    logic busy;
    logic okNow;
    logic okReg;
    logic [3:0] waitCnt;
    assign okNow = !failNext && (!linkCmd.speedChange || linkCmd.reqRate == SPD_GEN1
        || partnerRates[ADV_GEN2_BIT]);
    // Verdict latched at the request, since the command may move before done
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            waitCnt <= 4'h0;
            okReg <= 1'b0;
            recov <= '0;
        end else begin
            recov <= '0;
            if (linkCmd.recovReq) begin
                busy <= 1'b1;
                waitCnt <= slow ? 4'hc : 4'h1;
                okReg <= okNow;
            end else if (busy && waitCnt == 4'h0) begin
                busy <= 1'b0;
                recov <= '{done: 1'b1, ok: okReg, lockFail: 1'b0};
            end else if (busy) begin
                waitCnt <= waitCnt - 4'h1;
            end
        end
    end
endmodule // lsn_partner

// File: dv/lsn_link_speed_test.sv
// Purpose: Self-checking bench for the link speed negotiator
// Assumes: Zero-wait register bus, partner model answers every pass
// Notes: Downstream port only; upstream behaviour is not exercised
`timescale 1ns/1ps
module lsn_link_speed_test;
    import lsn_pkg::*;
    logic clk_sys = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, dlActive = 1'b0;
    logic unreliable = 1'b0, slow = 1'b0, failNext = 1'b0, hreadyout, hresp, bwNotify;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdWord;
    logic [1:0] htrans = 2'h0, partnerRates = 2'h3;
    logic [2:0] hsize = 3'h2;
    lsn_ltssm_e ltssmState = LT_DETECT;
    lsn_ts_rx_s tsRx = '0;
    lsn_part_req_s partnerReq = '0;
    lsn_recov_s recov;
    lsn_cmd_s linkCmd;
    int n_mismatch = 0, compares = 0, cycles = 0;
    lsn_link_speed DUT (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ltssmState(ltssmState),
        .dlActive(dlActive), .isDownstream(1'b1), .tsRx(tsRx), .partnerReq(partnerReq),
        .unreliable(unreliable), .recov(recov), .linkCmd(linkCmd), .bwNotify(bwNotify));
    lsn_partner peer (.clk_sys(clk_sys), .arst_n(arst_n), .linkCmd(linkCmd),
        .partnerRates(partnerRates), .slow(slow), .failNext(failNext), .recov(recov));
    // Clock and hang guard
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (n_mismatch == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One single transfer; read data taken at the edge closing the data phase
    task automatic bus(input logic wrt, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wrt;
        haddr <= {24'h0, a};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rdWord = hrdata;
    endtask
    // Detect restart when st is Configuration.Complete, else a Recovery advert
    task automatic train(input lsn_ltssm_e st, input logic [1:0] r);
        @(posedge clk_sys);
        ltssmState <= (st == LT_CFG_COMPLETE) ? LT_DETECT : st;
        dlActive <= (st != LT_CFG_COMPLETE);
        partnerRates <= r;
        @(posedge clk_sys);
        ltssmState <= st;
        tsRx <= {1'b1, r};
        @(posedge clk_sys);
        tsRx <= '0;
        ltssmState <= LT_L0;
        dlActive <= 1'b1;
    endtask
    task automatic kick(input lsn_part_req_s p, input logic u);
        @(posedge clk_sys);
        partnerReq <= p;
        unreliable <= u;
        @(posedge clk_sys);
        partnerReq <= '0;
        unreliable <= 1'b0;
    endtask
    task automatic no_pass(input int n);
        int hits;
        hits = 0;
        repeat (n) begin
            @(negedge clk_sys);
            if (linkCmd.recovReq !== 1'b0) hits++;
        end
        chk("unrequested pass", 32'(hits), 32'h0);
    endtask
    task automatic wait_pass(input logic sc, input logic [3:0] rate);
        int i;
        for (i = 0; i < 60 && linkCmd.recovReq !== 1'b1; i++) @(negedge clk_sys);
        chk("recovery request", {31'h0, linkCmd.recovReq}, 32'h1);
        chk("speed change bit", {31'h0, linkCmd.speedChange}, {31'h0, sc});
        chk("requested rate", {28'h0, linkCmd.reqRate}, {28'h0, rate});
        chk("autonomous flag", {31'h0, linkCmd.txAutonomous}, 32'h0);
        for (i = 0; i < 60 && recov.done !== 1'b1; i++) @(negedge clk_sys);
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic lane(input logic [3:0] r);
        chk("lane rate", {28'h0, linkCmd.laneRate}, {28'h0, r});
    endtask
    task automatic sts(input logic [31:0] exp);
        bus(1'b0, OFF_LINK_STS, 32'h0);
        chk("link status", rdWord, exp);
        bus(1'b1, OFF_LINK_STS, 32'h0000_c000);
    endtask
    task automatic s_reset();
        bus(1'b0, OFF_LINK_CTRL2, 32'h0);
        chk("target reset", rdWord, {28'h0, SPD_GEN2});
        bus(1'b1, OFF_LINK_CTRL2, 32'h0000_0022);
        bus(1'b0, OFF_LINK_CTRL2, 32'h0);
        chk("autonomy disable", rdWord, 32'h0000_0002);
        chk("advertised", {30'h0, linkCmd.advRates}, {30'h0, ADV_BOTH});
        chk("okay response", {31'h0, hresp}, 32'h0);
        chk("bus ready", {31'h0, hreadyout}, 32'h1);
        lane(SPD_GEN1);
    endtask
    task automatic s_auto();
        bus(1'b1, OFF_PHY_CFG0, 32'h1);
        train(LT_CFG_COMPLETE, ADV_BOTH);
        no_pass(20);
        lane(SPD_GEN1);
        bus(1'b1, OFF_PHY_CFG0, 32'h0);
        wait_pass(1'b1, SPD_GEN2);
        lane(SPD_GEN2);
        sts(32'h0000_0002);
    endtask
    task automatic s_host();
        bus(1'b1, OFF_LINK_CTRL, 32'h0000_0400);
        kick('0, 1'b1);
        wait_pass(1'b1, SPD_GEN1);
        chk("advert kept", {30'h0, linkCmd.advRates}, {30'h0, ADV_BOTH});
        chk("notify on", {31'h0, bwNotify}, 32'h1);
        sts(32'h0000_4001);
        bus(1'b1, OFF_LINK_CTRL, 32'h0000_0020);
        wait_pass(1'b1, SPD_GEN2);
        chk("notify off", {31'h0, bwNotify}, 32'h0);
        sts(32'h0000_4002);
        slow <= 1'b1;
        bus(1'b1, OFF_LINK_CTRL2, {28'h0, SPD_GEN1});
        // Hold-down pass starts at once; the retrain lands while busy
        fork
            wait_pass(1'b1, SPD_GEN1);
            bus(1'b1, OFF_LINK_CTRL, 32'h0000_0020);
        join
        slow <= 1'b0;
        no_pass(20);
        chk("advert cut", {30'h0, linkCmd.advRates}, {30'h0, ADV_GEN1_ONLY});
        sts(32'h0000_4001);
    endtask
    task automatic s_partner();
        bus(1'b1, OFF_LINK_CTRL2, {28'h0, SPD_GEN2});
        kick('{valid: 1'b1, rate: SPD_GEN2, autonomous: 1'b1}, 1'b0);
        wait_pass(1'b1, SPD_GEN2);
        sts(32'h0000_8002);
        kick('{valid: 1'b1, rate: SPD_GEN1, autonomous: 1'b0}, 1'b0);
        wait_pass(1'b1, SPD_GEN1);
        sts(32'h0000_4001);
    endtask
    task automatic s_fail();
        bus(1'b1, OFF_PHY_STATE0, 32'h1);
        @(negedge clk_sys);
        chk("full retrain", {31'h0, linkCmd.fullRetrain}, 32'h1);
        failNext <= 1'b1;
        train(LT_CFG_COMPLETE, ADV_BOTH);
        wait_pass(1'b1, SPD_GEN2);
        lane(SPD_GEN1);
        no_pass(30);
        bus(1'b0, OFF_PHY_STATE0, 32'h0);
        chk("upgrade failed", rdWord & 32'h1030, 32'h1030);
        failNext <= 1'b0;
        bus(1'b1, OFF_LINK_CTRL, 32'h0000_0020);
        wait_pass(1'b1, SPD_GEN2);
        lane(SPD_GEN2);
        train(LT_RCV_RCVRCFG, ADV_GEN1_ONLY);
        wait_pass(1'b1, SPD_GEN1);
        bus(1'b0, OFF_PHY_STATE0, 32'h0);
        chk("partner rates", rdWord & 32'h30, 32'h10);
        bus(1'b1, OFF_LINK_CTRL, 32'h0000_0020);
        wait_pass(1'b0, SPD_GEN1);
        lane(SPD_GEN1);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped read", rdWord, 32'h0);
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        s_reset();
        s_auto();
        s_host();
        s_partner();
        s_fail();
        print_verdict();
    end
endmodule // lsn_link_speed_test
